// File: core/dssc_defines.svh
// Constants for the drive setpoint and stop control block
`ifndef DSSC_DEFINES_SVH
`define DSSC_DEFINES_SVH

// Operating mode code reported and requested, fixed without motion control
`define DSSC_VELOCITY_MODE_CODE 8'h02

// Control word bit positions
`define DSSC_CW_START           0
`define DSSC_CW_EN_VOLT         1
`define DSSC_CW_QSTOP_N         2
`define DSSC_CW_EN_OP           3

// Disable-operation transition settings
`define DSSC_STOP_COAST         2'h0
`define DSSC_STOP_DC            2'h1
`define DSSC_STOP_RAMP          2'h2

// Ramp input selection
`define DSSC_RSEL_INTERNAL      2'h1
`define DSSC_RSEL_BUS           2'h2
`define DSSC_RSEL_SUM           2'h3

// Setpoint word scaling: 100 percent of base is 2 to the 14
`define DSSC_SCALE_SHIFT        14
`define DSSC_WORD_MAX           16'h7FFF
`define DSSC_WORD_MIN           16'h8000
`define DSSC_PCT_DIV            100

// Timing: one millisecond in ns, clock period in ns
`define DSSC_MS_NS              1000000
`define DSSC_CLK_NS             10

`endif

// File: core/dssc_pkg.sv
// Types shared by the drive setpoint and stop control block
package dssc_pkg;

  // Signed frequency in units of 0.01 Hz
  typedef logic signed [18:0] dssc_freq_t;

  // Unsigned frequency setting in units of 0.01 Hz
  typedef logic [16:0] dssc_fset_t;

  typedef enum logic [2:0] {
    st_switched_on,
    st_enabled,
    st_quick_stop,
    st_stop_ramp,
    st_dc_brake
  } dssc_state_t;

endpackage : dssc_pkg

// File: core/dssc_ref_scale.sv
// Setpoint word to frequency and frequency to actual word scaling
`timescale 1ns/100ps
`include "dssc_defines.svh"

module dssc_ref_scale
  import dssc_pkg::*;
(
  // Scaling base and limit
  input  wire logic [16:0]       scale_base,
  input  wire logic [16:0]       freq_limit,
  // Words and frequencies
  input  wire logic [15:0]       setpoint_word,
  input  wire logic signed [18:0] drive_freq,
  output logic signed [18:0]     bus_freq,
  output logic [15:0]            actual_word
);

  logic signed [34:0] prod;
  logic signed [34:0] scaled;
  logic signed [34:0] lim_pos;
  logic signed [34:0] lim_neg;
  logic signed [34:0] act_num;
  logic signed [34:0] act_quo;

  assign prod    = $signed({{19{setpoint_word[15]}}, setpoint_word}) * $signed({18'h0_0000, scale_base});
  assign scaled  = prod >>> `DSSC_SCALE_SHIFT;
  assign lim_pos = $signed({18'h0_0000, freq_limit});
  assign lim_neg = -lim_pos;

  // Saturate to plus or minus the frequency limit
  assign bus_freq = (scaled > lim_pos) ? 19'(lim_pos) :
                    (scaled < lim_neg) ? 19'(lim_neg) : 19'(scaled);

  // Actual word uses the same base so 0x4000 is full base
  assign act_num = $signed({{2{drive_freq[18]}}, drive_freq, 14'h0000});
  assign act_quo = (scale_base == 17'h0_0000) ? 35'sh0 :
                   act_num / $signed({18'h0_0000, scale_base});
  assign actual_word = (act_quo > $signed({19'h0_0000, `DSSC_WORD_MAX})) ? `DSSC_WORD_MAX :
                       (act_quo < -35'sh8000) ? `DSSC_WORD_MIN : act_quo[15:0];

endmodule : dssc_ref_scale

// File: core/dssc_drive_ctrl.sv
// Velocity-mode stop control and reference path for a fieldbus inverter
// What this block does
// - Mode and readback fixed at velocity code
// - Quick stop uses per-direction emergency ramps
// - Keep current on until holding time ends
// - Leave enabled after threshold then holding time
// - Setting picks coast, DC brake or ramp
// - Setting defaults ramp, coast under torque control
// - DC brake setting refused without V/f control
// - DC brake ignores control words until braking ends
// - Enable again during ramp-down re-accelerates
// - Setpoint in second output, actual in second input
// - Base is bus reference, else rated frequency
// - 0x4000 is plus, 0xC000 minus full base
// - Ramp input internal, bus, or signed sum
// - Bus-only reference clamped to minimum frequency
// - Zero bus reference keeps last nonzero sign
// - After power-up clamp is positive minimum
// - Summed reference sign from the sum
`timescale 1ns/100ps
`include "dssc_defines.svh"

module dssc_drive_ctrl
  import dssc_pkg::*;
#(
  parameter int MS_CYCLES = `DSSC_MS_NS / `DSSC_CLK_NS
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Cyclic fieldbus words
  input  wire logic [15:0]       control_word,
  input  wire logic [15:0]       setpoint_word,
  output logic [15:0]            actual_word,
  output logic [7:0]             mode_of_operation,
  output logic [7:0]             mode_display,
  // Configuration
  input  wire logic              torque_config,
  input  wire logic              vf_config,
  input  wire logic              stop_mode_wr,
  input  wire logic [1:0]        stop_mode_in,
  input  wire logic              ramp_sel_wr,
  input  wire logic [1:0]        ramp_sel_in,
  input  wire logic [16:0]       bus_ref_base,
  input  wire logic [16:0]       rated_freq,
  input  wire logic [16:0]       min_freq,
  input  wire logic [16:0]       max_freq,
  input  wire logic signed [18:0] internal_ref,
  input  wire logic [6:0]        threshold_pct,
  input  wire logic [15:0]       hold_time_ms,
  input  wire logic [15:0]       brake_time_ms,
  input  wire logic [16:0]       accel_step,
  input  wire logic [16:0]       decel_step,
  input  wire logic [16:0]       estop_step_cw,
  input  wire logic [16:0]       estop_step_ccw,
  // Drive status
  output logic [1:0]             stop_mode,
  output logic [1:0]             ramp_select,
  output logic signed [18:0]     ramp_reference,
  output logic signed [18:0]     drive_freq,
  output logic                   switched_on,
  output logic                   op_enabled,
  output logic                   quick_stop_active,
  output logic                   dc_brake_active,
  output logic                   current_on
);

  dssc_state_t        state;
  dssc_state_t        next_state;
  logic               init_done;
  logic               last_neg;
  logic [16:0]        ms_cnt;
  logic [15:0]        timer_ms;
  logic               ms_tick;
  logic               timing;
  logic               expired;
  logic               below;
  logic [16:0]        scale_base;
  logic signed [18:0] bus_freq;
  logic [15:0]        actual_next;
  logic signed [18:0] min_pos;
  logic signed [18:0] bus_clamped;
  logic signed [19:0] sum_ref;
  logic signed [18:0] target;
  logic signed [18:0] step;
  logic signed [18:0] next_freq;
  logic [23:0]        thr_prod;
  logic signed [18:0] threshold;
  logic [18:0]        freq_mag;
  logic               cmd_enable;
  logic               cmd_disable;
  logic               cmd_qstop;
  logic               cmd_off;

  function automatic logic is_enable(input logic [15:0] cw);
    is_enable = cw[`DSSC_CW_EN_OP] & cw[`DSSC_CW_QSTOP_N] & cw[`DSSC_CW_EN_VOLT]
                & cw[`DSSC_CW_START];
  endfunction : is_enable

  function automatic logic signed [18:0] mag(input logic signed [18:0] v);
    mag = v[18] ? -v : v;
  endfunction : mag

  // Control word decode
  assign cmd_enable  = is_enable(control_word);
  assign cmd_qstop   = control_word[`DSSC_CW_EN_VOLT] & ~control_word[`DSSC_CW_QSTOP_N];
  assign cmd_off     = ~control_word[`DSSC_CW_EN_VOLT];
  assign cmd_disable = ~control_word[`DSSC_CW_EN_OP] & control_word[`DSSC_CW_QSTOP_N]
                       & control_word[`DSSC_CW_EN_VOLT];

  assign mode_of_operation = `DSSC_VELOCITY_MODE_CODE;
  assign mode_display      = `DSSC_VELOCITY_MODE_CODE;

  // Scaling base selection
  assign scale_base = (bus_ref_base != 17'h0_0000) ? bus_ref_base : rated_freq;

  dssc_ref_scale u_scale (
    .scale_base    (scale_base),
    .freq_limit    (max_freq),
    .setpoint_word (setpoint_word),
    .drive_freq    (drive_freq),
    .bus_freq      (bus_freq),
    .actual_word   (actual_next)
  );

  // Bus-only clamp with remembered sign; zero has no sign so the last one is used
  assign min_pos     = $signed({2'b00, min_freq});
  assign bus_clamped = (bus_freq == 19'sh0) ? (last_neg ? -min_pos : min_pos) :
                       (mag(bus_freq) < min_pos) ? (bus_freq[18] ? -min_pos : min_pos) :
                       bus_freq;
  assign sum_ref     = 20'(internal_ref) + 20'(bus_freq);

  assign ramp_reference = (ramp_select == `DSSC_RSEL_INTERNAL) ? internal_ref :
                          (ramp_select == `DSSC_RSEL_BUS) ? bus_clamped :
                          (sum_ref > 20'sh3_FFFF) ? 19'sh3_FFFF :
                          (sum_ref < -20'sh3_FFFF) ? -19'sh3_FFFF : sum_ref[18:0];

  // Switch-off threshold as percent of maximum frequency
  assign thr_prod  = 24'(max_freq) * 24'(threshold_pct);
  assign threshold = $signed(19'(thr_prod / 24'(`DSSC_PCT_DIV)));
  assign freq_mag  = mag(drive_freq);
  assign below     = $signed(freq_mag) < threshold;

  // Ramp target and slope
  assign target = (state == st_enabled) ? ramp_reference : 19'sh0;
  assign step   = (state == st_quick_stop) ?
                    (drive_freq[18] ? $signed({2'b00, estop_step_ccw}) :
                                      $signed({2'b00, estop_step_cw})) :
                  (mag(target) > $signed(freq_mag)) ? $signed({2'b00, accel_step}) :
                  $signed({2'b00, decel_step});
  assign next_freq = (state == st_switched_on || state == st_dc_brake) ? 19'sh0 :
                     (target > drive_freq) ?
                       ((target - drive_freq > step) ? drive_freq + step : target) :
                       ((drive_freq - target > step) ? drive_freq - step : target);

  // Millisecond timebase; too long at 100 MHz to count raw cycles for seconds
  assign ms_tick = (ms_cnt == 17'(MS_CYCLES - 1));
  assign timing  = ((state == st_quick_stop || state == st_stop_ramp) && below)
                   || state == st_dc_brake;
  assign expired = (state == st_dc_brake) ? (timer_ms >= brake_time_ms) :
                   (timer_ms >= hold_time_ms);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ms_cnt   <= 17'h0_0000;
      timer_ms <= 16'h0000;
    end
    else
    begin
      ms_cnt   <= (!timing || ms_tick) ? 17'h0_0000 : ms_cnt + 17'h0_0001;
      timer_ms <= !timing ? 16'h0000 :
                  (ms_tick && !expired) ? timer_ms + 16'h0001 : timer_ms;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      st_switched_on:
        if (cmd_enable)
          next_state = st_enabled;
      st_enabled:
        if (cmd_off)
          next_state = st_switched_on;
        else if (cmd_qstop)
          next_state = st_quick_stop;
        else if (cmd_disable)
        begin
          case (stop_mode)
            `DSSC_STOP_COAST: next_state = st_switched_on;
            `DSSC_STOP_DC:    next_state = st_dc_brake;
            default:          next_state = st_stop_ramp;
          endcase
        end
      st_quick_stop:
        if (cmd_off)
          next_state = st_switched_on;
        else if (below && expired)
          next_state = st_switched_on;
      st_stop_ramp:
        if (cmd_off)
          next_state = st_switched_on;
        else if (cmd_qstop)
          next_state = st_quick_stop;
        else if (cmd_enable)
          next_state = st_enabled;
        else if (below && expired)
          next_state = st_switched_on;
      st_dc_brake:
        if (expired)
          next_state = st_switched_on;
      default:
        next_state = st_switched_on;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state       <= st_switched_on;
      drive_freq  <= 19'sh0;
      actual_word <= 16'h0000;
    end
    else
    begin
      state       <= next_state;
      drive_freq  <= (next_state == st_switched_on) ? 19'sh0 : next_freq;
      actual_word <= actual_next;
    end
  end

  // Sign of last nonzero bus reference, positive from power-up
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      last_neg <= 1'b0;
    else if (bus_freq != 19'sh0)
      last_neg <= bus_freq[18];
  end

  // Settings: stop-mode default caught once after reset release, since torque strap is a port; ramp select default loaded by reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      init_done   <= 1'b0;
      stop_mode   <= `DSSC_STOP_RAMP;
      ramp_select <= `DSSC_RSEL_SUM;
    end
    else
    begin
      init_done <= 1'b1;
      if (!init_done)
        stop_mode <= torque_config ? `DSSC_STOP_COAST : `DSSC_STOP_RAMP;
      else if (stop_mode_wr && stop_mode_in <= `DSSC_STOP_RAMP
               && (stop_mode_in != `DSSC_STOP_DC || vf_config))
        stop_mode <= stop_mode_in;
      if (ramp_sel_wr && ramp_sel_in != 2'h0)
        ramp_select <= ramp_sel_in;
    end
  end

  assign switched_on       = 1'b1; // Every modelled state is switched on or beyond
  assign op_enabled        = (state == st_enabled) || (state == st_quick_stop)
                             || (state == st_stop_ramp) || (state == st_dc_brake);
  assign quick_stop_active = (state == st_quick_stop);
  assign dc_brake_active   = (state == st_dc_brake);
  assign current_on        = (state != st_switched_on);

  sequence s_coast_cmd;
    state == st_enabled && !cmd_off && !cmd_qstop && cmd_disable
      && stop_mode == `DSSC_STOP_COAST;
  endsequence

  sequence s_braking;
    state == st_dc_brake && !expired;
  endsequence

  sequence s_ramp_resume;
    state == st_stop_ramp && !cmd_off && !cmd_qstop && cmd_enable;
  endsequence

  a_mode_fixed: assert property (@(posedge clock) disable iff (!resetn)
    mode_of_operation == 8'h02 && mode_display == 8'h02)
    else $error("operating mode left velocity mode");

  a_qstop_current: assert property (@(posedge clock) disable iff (!resetn)
    state == st_quick_stop && !(below && expired) && !cmd_off
      |=> state == st_quick_stop && current_on)
    else $error("quick stop ended before holding time");

  a_stop_exit: assert property (@(posedge clock) disable iff (!resetn)
    $past(state) == st_stop_ramp && state == st_switched_on && $past(resetn)
      |-> $past(cmd_off || (below && expired)))
    else $error("ramp stop left before threshold and hold");

  a_coast_now: assert property (@(posedge clock) disable iff (!resetn)
    s_coast_cmd |=> state == st_switched_on && drive_freq == 19'sh0)
    else $error("coast did not switch off at once");

  a_dc_refused: assert property (@(posedge clock) disable iff (!resetn)
    init_done && stop_mode_wr && stop_mode_in == `DSSC_STOP_DC && !vf_config
      |=> stop_mode == $past(stop_mode))
    else $error("DC brake setting accepted without V/f");

  a_dc_ignore: assert property (@(posedge clock) disable iff (!resetn)
    s_braking |=> state == st_dc_brake)
    else $error("DC brake left before braking time");

  a_ramp_resume: assert property (@(posedge clock) disable iff (!resetn)
    s_ramp_resume |=> state == st_enabled)
    else $error("enable during ramp-down not taken");

  a_zero_sign: assert property (@(posedge clock) disable iff (!resetn)
    ramp_select == `DSSC_RSEL_BUS && bus_freq == 19'sh0
      |-> ramp_reference == (last_neg ? -min_pos : min_pos))
    else $error("zero bus reference has wrong minimum sign");

  a_bus_clamp: assert property (@(posedge clock) disable iff (!resetn)
    ramp_select == `DSSC_RSEL_BUS |-> mag(ramp_reference) >= min_pos)
    else $error("bus reference below minimum frequency");

  a_sum_sign: assert property (@(posedge clock) disable iff (!resetn)
    ramp_select == `DSSC_RSEL_SUM && sum_ref != 20'sh0 |-> ramp_reference[18] == sum_ref[19])
    else $error("summed reference sign wrong");

endmodule : dssc_drive_ctrl

// File: tb/dssc_bus_master.sv
// Fieldbus controller model driving the cyclic control and setpoint words
`timescale 1ns/100ps

module dssc_bus_master
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Words the bench wants sent next cycle
  input  wire logic [15:0] next_control,
  input  wire logic [15:0] next_setpoint,
  // Cyclic output words
  output logic      [15:0] control_word,
  output logic      [15:0] setpoint_word
);
  // One update per cycle, as a cyclic bus would; zero words while in reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      control_word  <= 16'h0000;
      setpoint_word <= 16'h0000;
    end
    else
    begin
      control_word  <= next_control;
      setpoint_word <= next_setpoint;
    end
  end
endmodule : dssc_bus_master

// File: tb/dssc_drive_ctrl_test.sv
// Self-checking bench for the drive setpoint and stop control block
`timescale 1ns/100ps

module dssc_drive_ctrl_test;
  import dssc_pkg::*;
  logic clock, resetn, torque_config, vf_config, stop_mode_wr, ramp_sel_wr;
  logic [15:0] cmd_word, cmd_setpoint, control_word, setpoint_word, actual_word;
  logic [15:0] hold_time_ms, brake_time_ms;
  logic [7:0] mode_of_operation, mode_display;
  logic [6:0] threshold_pct;
  logic [1:0] stop_mode_in, ramp_sel_in, stop_mode, ramp_select;
  logic [16:0] bus_ref_base, rated_freq, min_freq, max_freq;
  logic [16:0] accel_step, decel_step, estop_step_cw, estop_step_ccw;
  logic signed [18:0] internal_ref, ramp_reference, drive_freq, prev_freq;
  logic switched_on, op_enabled, quick_stop_active, dc_brake_active, current_on;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  dssc_bus_master bus (.clock(clock), .resetn(resetn), .next_control(cmd_word),
    .next_setpoint(cmd_setpoint), .control_word(control_word),
    .setpoint_word(setpoint_word));

  dssc_drive_ctrl #(.MS_CYCLES(10)) dut (.clock(clock), .resetn(resetn),
    .control_word(control_word), .setpoint_word(setpoint_word),
    .actual_word(actual_word), .mode_of_operation(mode_of_operation),
    .mode_display(mode_display), .torque_config(torque_config),
    .vf_config(vf_config), .stop_mode_wr(stop_mode_wr), .stop_mode_in(stop_mode_in),
    .ramp_sel_wr(ramp_sel_wr), .ramp_sel_in(ramp_sel_in), .bus_ref_base(bus_ref_base),
    .rated_freq(rated_freq), .min_freq(min_freq), .max_freq(max_freq),
    .internal_ref(internal_ref), .threshold_pct(threshold_pct),
    .hold_time_ms(hold_time_ms), .brake_time_ms(brake_time_ms),
    .accel_step(accel_step), .decel_step(decel_step), .estop_step_cw(estop_step_cw),
    .estop_step_ccw(estop_step_ccw), .stop_mode(stop_mode), .ramp_select(ramp_select),
    .ramp_reference(ramp_reference), .drive_freq(drive_freq),
    .switched_on(switched_on), .op_enabled(op_enabled),
    .quick_stop_active(quick_stop_active), .dc_brake_active(dc_brake_active),
    .current_on(current_on));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input logic [18:0] seen, input logic [18:0] want);
    comparisons++;
    if (seen !== want)
    begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask : tick

  task automatic set_cmd(input logic [15:0] w);
    @(posedge clock);
    cmd_word <= w;
    // Return off the edge so waits read settled outputs
    @(negedge clock);
  endtask : set_cmd

  // Partner adds a cycle, so settle two edges before looking
  task automatic set_sp(input logic [15:0] w);
    @(posedge clock);
    cmd_setpoint <= w;
    tick(2);
    @(negedge clock);
  endtask : set_sp

  task automatic wr_stop(input logic [1:0] v);
    @(posedge clock);
    stop_mode_wr <= 1'b1;
    stop_mode_in <= v;
    @(posedge clock);
    stop_mode_wr <= 1'b0;
    @(negedge clock);
  endtask : wr_stop

  task automatic wr_ramp(input logic [1:0] v);
    @(posedge clock);
    ramp_sel_wr <= 1'b1;
    ramp_sel_in <= v;
    @(posedge clock);
    ramp_sel_wr <= 1'b0;
    @(negedge clock);
  endtask : wr_ramp

  function automatic logic seen_now(input int sel, input logic signed [18:0] v);
    case (sel)
      0: return op_enabled === v[0];
      1: return dc_brake_active === v[0];
      default: return drive_freq === v;
    endcase
  endfunction : seen_now

  // Bounded wait; the caller judges the cycle count
  task automatic wait_for(input int sel, input logic signed [18:0] v, output int k);
    k = 0;
    while (!seen_now(sel, v) && k < 60)
    begin
      @(negedge clock);
      k++;
    end
  endtask : wait_for

  task automatic test_defaults(input logic tq);
    @(posedge clock);
    resetn <= 1'b0;
    torque_config <= tq;
    tick(8);
    resetn <= 1'b1;
    tick(2);
    @(negedge clock);
    check(mode_of_operation, 8'h02);
    check(mode_display, 8'h02);
    check(stop_mode, tq ? 2'h0 : 2'h2);
    check(ramp_select, 2'h3);
    check({switched_on, op_enabled, current_on}, 3'b100);
  endtask : test_defaults

  task automatic test_settings;
    wr_stop(2'h1);
    wr_stop(2'h3);
    check(stop_mode, 2'h2);
    @(posedge clock);
    vf_config <= 1'b1;
    wr_stop(2'h1);
    check(stop_mode, 2'h1);
    wr_stop(2'h0);
    check(stop_mode, 2'h0);
    @(posedge clock);
    vf_config <= 1'b0;
    wr_ramp(2'h0);
    check(ramp_select, 2'h3);
    for (int v = 1; v <= 3; v++)
    begin
      wr_ramp(v[1:0]);
      check(ramp_select, v[1:0]);
    end
  endtask : test_settings

  task automatic test_reference;
    wr_ramp(2'h2);
    check(ramp_reference, 19'sd500);
    set_sp(16'h4000);
    check(ramp_reference, 19'sd5000);
    set_sp(16'hC000);
    check(ramp_reference, -19'sd5000);
    set_sp(16'h0000);
    check(ramp_reference, -19'sd500);
    set_sp(16'h0100);
    check(ramp_reference, 19'sd500);
    set_sp(16'h7FFF);
    check(ramp_reference, 19'sd8000);
    set_sp(16'h8000);
    check(ramp_reference, -19'sd8000);
    @(posedge clock);
    bus_ref_base <= 17'h0_1770;
    set_sp(16'h2000);
    check(ramp_reference, 19'sd3000);
    @(posedge clock);
    internal_ref <= -19'sd4000;
    wr_ramp(2'h3);
    check(ramp_reference, -19'sd1000);
    wr_ramp(2'h1);
    check(ramp_reference, -19'sd4000);
  endtask : test_reference

  task automatic test_motion;
    @(posedge clock);
    bus_ref_base <= 17'h0_1000;
    internal_ref <= 19'sd1000;
    wr_stop(2'h2);
    set_cmd(16'h000F);
    wait_for(2, 19'sd1000, n);
    tick(2);
    @(negedge clock);
    check(actual_word, 16'h0FA0);
    set_cmd(16'h0007);
    tick(4);
    @(negedge clock);
    check({op_enabled, drive_freq < 19'sd1000}, 2'b11);
    set_cmd(16'h000F);
    wait_for(2, 19'sd1000, n);
    check({op_enabled, n < 60}, 2'b11);
    set_cmd(16'h0007);
    wait_for(2, 19'sd0, n);
    check({op_enabled, current_on}, 2'b11);
    wait_for(0, 19'sd0, n);
    check({current_on, n >= 5 && n < 40}, 2'b01);
    set_cmd(16'h000F);
    wait_for(2, 19'sd1000, n);
    set_cmd(16'h0003);
    tick(2);
    @(negedge clock);
    prev_freq = drive_freq;
    @(negedge clock);
    check(quick_stop_active, 1'b1);
    check(prev_freq - drive_freq, 19'sd250);
    wait_for(2, 19'sd0, n);
    check({quick_stop_active, current_on}, 2'b11);
    wait_for(0, 19'sd0, n);
    check(n >= 5 && n < 60, 1'b1);
    @(posedge clock);
    internal_ref <= -19'sd1000;
    set_cmd(16'h000F);
    wait_for(2, -19'sd1000, n);
    tick(2);
    @(negedge clock);
    check(actual_word, 16'hF060);
    set_cmd(16'h0003);
    tick(2);
    @(negedge clock);
    prev_freq = drive_freq;
    @(negedge clock);
    check(drive_freq - prev_freq, 19'sd150);
    wait_for(0, 19'sd0, n);
    @(posedge clock);
    internal_ref <= 19'sd1000;
    wr_stop(2'h0);
    set_cmd(16'h000F);
    wait_for(2, 19'sd1000, n);
    set_cmd(16'h0007);
    wait_for(0, 19'sd0, n);
    check(n <= 3, 1'b1);
    @(posedge clock);
    vf_config <= 1'b1;
    wr_stop(2'h1);
    set_cmd(16'h000F);
    wait_for(2, 19'sd1000, n);
    set_cmd(16'h0007);
    tick(3);
    set_cmd(16'h000F);
    @(negedge clock);
    check(dc_brake_active, 1'b1);
    wait_for(1, 19'sd0, n);
    check(n >= 4 && n <= 12, 1'b1);
    set_cmd(16'h0000);
  endtask : test_motion

  initial
  begin
    resetn = 1'b0;
    {torque_config, vf_config, stop_mode_wr, ramp_sel_wr} = 4'h0;
    {stop_mode_in, ramp_sel_in} = 4'h0;
    {cmd_word, cmd_setpoint} = 32'h0000_0000;
    bus_ref_base = 17'h0_0000;
    rated_freq = 17'h0_1388;
    min_freq = 17'h0_01F4;
    max_freq = 17'h0_1F40;
    internal_ref = 19'sd0;
    threshold_pct = 7'h0A;
    hold_time_ms = 16'h0002;
    brake_time_ms = 16'h0001;
    accel_step = 17'h0_0064;
    decel_step = 17'h0_0064;
    estop_step_cw = 17'h0_00FA;
    estop_step_ccw = 17'h0_0096;
    test_defaults(1'b1);
    test_defaults(1'b0);
    test_settings();
    test_reference();
    test_motion();
    stop_test();
  end
endmodule : dssc_drive_ctrl_test
